// ---- logic/clmg_top.sv ----
// Functional notes
// - Parking mode serves references from 25 to 400 MHz
// - First output edge within 1.6 ms of power-up
// - First output edge within 87 ns of power-down release
// - Output start/stop 4 to 6 reference cycles after enable
// - Loss flagged within 300 ns of clock stopping
// - Parking enabled: outputs low/low within loss time
// - Loss released within 7 reference cycles of return
// - Parking enabled: on return drive high/low first, then toggle
// - Presence judged by edges only, not frequency
// - Hold reset, no loss detection before first edge
`timescale 1ns/1ns
module clmg_top
#(
	parameter int          NUM_OUTPUTS = 8,
	parameter int unsigned POWERUP_CYC = clmg_pkg::POWERUP_CYC_DEF
) (
	// Core clock and reset
	input  wire logic                         CORE_CLK,
	input  wire logic                         RESET,
	// Reference clock and control pins
	input  wire logic                         REFERENCE_CLOCK_IN,
	input  wire logic                         OUTPUT_ENABLE_N,
	input  wire logic                         POWER_GOOD_POWERDOWN_N,
	// Output pairs
	output logic      [NUM_OUTPUTS-1:0]       OUT_TRUE,
	output logic      [NUM_OUTPUTS-1:0]       OUT_COMP,
	// Open-drain loss indicator
	output logic                              INPUT_CLOCK_LOSS_N_O,
	output logic                              INPUT_CLOCK_LOSS_N_OE,
	// Register port
	input  wire logic [clmg_pkg::ADDR_W-1:0]  REG_ADDR,
	input  wire logic [clmg_pkg::DATA_W-1:0]  REG_WDATA,
	input  wire logic                         REG_WR,
	input  wire logic                         REG_RD,
	output logic      [clmg_pkg::DATA_W-1:0]  REG_RDATA,
	// Interrupt
	output logic                              IRQ
);
	import clmg_pkg::*;

	localparam int PW = $clog2(POWERUP_CYC + 1);

	clmg_state_t       state_q;
	clmg_state_t       state_d;
	logic              ref_s;
	logic              oe_n_s;
	logic              pg_s;
	logic              ref_rise;
	logic              ref_edge;
	logic              ref_silent;
	logic              loss_q;
	logic [2:0]        ret_cnt_q;
	logic              out_en_q;
	logic [2:0]        oe_cnt_q;
	logic [PW-1:0]     por_cnt_q;
	logic              late_q;
	logic              park_en_q;
	logic [IRQ_W-1:0]  irq_stat_q;
	logic [IRQ_W-1:0]  irq_mask_q;
	logic [IRQ_W-1:0]  irq_evt;
	logic              loss_set;
	logic              loss_clr;
	logic              late_evt;

	// Elaboration checks
	if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 8) begin : g_bad_outputs
		$error("clmg_top: NUM_OUTPUTS must be 1 to 8");
	end
	if (POWERUP_CYC < 1) begin : g_bad_powerup
		$error("clmg_top: POWERUP_CYC must be at least 1");
	end
	// A 25 MHz half period must fit inside the silence window
	if (LOSS_SILENT_CYC * CLK_PERIOD_NS <= REF_HALF_MAX_NS) begin : g_bad_window
		$error("clmg_top: silence window shorter than slowest reference half period");
	end
	if (RETURN_EDGES > RETURN_EDGES_MAX || OE_LAT_EDGES < OE_LAT_MIN || OE_LAT_EDGES > OE_LAT_MAX) begin : g_bad_cnt
		$error("clmg_top: edge counts out of range");
	end

	// Register write decode
	function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return REG_WR && (a == off);
	endfunction

	// Pins cross in through two flops each
	clmg_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.clk      (CORE_CLK),
		.rst      (RESET),
		.async_in ({REFERENCE_CLOCK_IN, OUTPUT_ENABLE_N, POWER_GOOD_POWERDOWN_N}),
		.sync_out ({ref_s, oe_n_s, pg_s})
	);

	// Edge detection on the synchronised reference
	clmg_edge_watch #(
		.SILENT_CYC(LOSS_SILENT_CYC)
	) u_edge (
		.clk      (CORE_CLK),
		.rst      (RESET),
		.level    (ref_s),
		.rise     (ref_rise),
		.any_edge (ref_edge),
		.silent   (ref_silent)
	);

	// Loss flag: set on silence while powered, released after a few rising edges
	// An edge in the very cycle the silence flag rises still counts as presence
	assign loss_set = ref_silent && !ref_edge && pg_s && !loss_q && (state_q != ST_POR);
	assign loss_clr = loss_q && ref_rise && (ret_cnt_q == 3'(RETURN_EDGES - 1));

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			loss_q    <= 1'b0;
			ret_cnt_q <= 3'h0;
		end else if (loss_set) begin
			loss_q    <= 1'b1;
			ret_cnt_q <= 3'h0;
		end else if (loss_clr || (loss_q && !pg_s)) begin
			loss_q    <= 1'b0;
			ret_cnt_q <= 3'h0;
		end else if (loss_q && ref_rise) begin
			ret_cnt_q <= ret_cnt_q + 3'h1;
		end
	end

	// Supervisor state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_POR: begin
				// Internal reset held until the first reference edge
				if (ref_rise) begin
					state_d = pg_s ? ST_RUN : ST_DOWN;
				end
			end
			ST_DOWN: begin
				if (pg_s) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!pg_s) begin
					state_d = ST_DOWN;
				end else if (loss_set && park_en_q) begin
					state_d = ST_PARK;
				end
			end
			ST_PARK: begin
				if (!pg_s) begin
					state_d = ST_DOWN;
				end else if (ref_rise) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!pg_s) begin
					state_d = ST_DOWN;
				end else if (loss_clr) begin
					state_d = ST_RUN;
				end else if (loss_set) begin
					state_d = ST_PARK;
				end
			end
			default: begin
				state_d = ST_POR;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			state_q <= ST_POR;
		end else begin
			state_q <= state_d;
		end
	end

	// Enable latency counted in reference edges; a stopped reference freezes it
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			out_en_q <= 1'b0;
			oe_cnt_q <= 3'h0;
		end else if (out_en_q == ~oe_n_s) begin
			oe_cnt_q <= 3'h0; // Pin agrees with outputs
		end else if (ref_rise) begin
			if (oe_cnt_q == 3'(OE_LAT_EDGES - 1)) begin
				out_en_q <= ~oe_n_s;
				oe_cnt_q <= 3'h0;
			end else begin
				oe_cnt_q <= oe_cnt_q + 3'h1;
			end
		end
	end

	// Output pairs registered; parking wins over the enable
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			OUT_TRUE <= '0;
			OUT_COMP <= '0;
		end else if (state_q == ST_HOLD && out_en_q) begin
			OUT_TRUE <= '1;
			OUT_COMP <= '0;
		end else if (state_q == ST_RUN && out_en_q) begin
			OUT_TRUE <= {NUM_OUTPUTS{ref_s}};
			OUT_COMP <= {NUM_OUTPUTS{~ref_s}};
		end else begin
			OUT_TRUE <= '0;
			OUT_COMP <= '0;
		end
	end

	// Open-drain: only ever pulls low, while loss stands
	assign INPUT_CLOCK_LOSS_N_O  = 1'b0;
	assign INPUT_CLOCK_LOSS_N_OE = loss_q;

	// Watchdog on the power-up wait; a late reference raises an event once
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			por_cnt_q <= '0;
			late_q    <= 1'b0;
		end else if (state_q == ST_POR && !late_q) begin
			if (por_cnt_q == PW'(POWERUP_CYC - 1)) begin
				late_q <= 1'b1;
			end else begin
				por_cnt_q <= por_cnt_q + 1'b1;
			end
		end
	end
	assign late_evt = (state_q == ST_POR) && !late_q && (por_cnt_q == PW'(POWERUP_CYC - 1));

	// Control register: parking enable
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			park_en_q <= CTRL_RESET[CTRL_PARK_BIT];
		end else if (wr_hit(REG_ADDR, REG_CTRL)) begin
			park_en_q <= REG_WDATA[CTRL_PARK_BIT];
		end
	end

	// Interrupt mask
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			irq_mask_q <= IRQ_MASK_RESET;
		end else if (wr_hit(REG_ADDR, REG_IRQ_MASK)) begin
			irq_mask_q <= REG_WDATA[IRQ_W-1:0];
		end
	end

	// Sticky status, write one to clear; a same-cycle event survives the clear
	always_comb begin
		irq_evt                   = '0;
		irq_evt[IRQ_LOSS_SET_BIT] = loss_set;
		irq_evt[IRQ_LOSS_CLR_BIT] = loss_clr;
		irq_evt[IRQ_LATE_BIT]     = late_evt;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			irq_stat_q <= '0;
		end else if (wr_hit(REG_ADDR, REG_IRQ_STAT)) begin
			irq_stat_q <= (irq_stat_q & ~REG_WDATA[IRQ_W-1:0]) | irq_evt;
		end else begin
			irq_stat_q <= irq_stat_q | irq_evt;
		end
	end

	assign IRQ = |(irq_stat_q & irq_mask_q);

	// Read data stand for one cycle only; unmapped reads return zero
	always_ff @(posedge CORE_CLK) begin
		if (RESET || !REG_RD) begin
			REG_RDATA <= '0;
		end else if (REG_ADDR == REG_CTRL) begin
			REG_RDATA <= DATA_W'({park_en_q, 4'h0});
		end else if (REG_ADDR == REG_STATUS) begin
			REG_RDATA <= {state_q, 1'b0, out_en_q, loss_q};
		end else if (REG_ADDR == REG_IRQ_STAT) begin
			REG_RDATA <= DATA_W'(irq_stat_q);
		end else if (REG_ADDR == REG_IRQ_MASK) begin
			REG_RDATA <= DATA_W'(irq_mask_q);
		end else begin
			REG_RDATA <= '0;
		end
	end

	// Checks
	localparam int LOSS_CHECK = LOSS_SILENT_CYC + 2;

	logic [4:0] quiet_h;
	logic [3:0] ret_h;

	always_ff @(posedge CORE_CLK) begin
		if (RESET || ref_edge) begin
			quiet_h <= 5'h00;
		end else if (quiet_h != 5'h1F) begin
			quiet_h <= quiet_h + 5'h01;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET || !loss_q) begin
			ret_h <= 4'h0;
		end else if (ref_rise && ret_h != 4'hF) begin
			ret_h <= ret_h + 4'h1;
		end
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	a_loss_assert_time: assert property ((quiet_h == 5'(LOSS_CHECK)) && pg_s && state_q != ST_POR |-> loss_q)
		else $error("loss not flagged within the assert time");
	a_park_low_low: assert property ($rose(loss_q) && park_en_q && pg_s |=> (OUT_TRUE == '0) && (OUT_COMP == '0))
		else $error("outputs not parked low after loss");
	a_loss_release_bound: assert property (loss_q && pg_s |-> ret_h <= 4'(RETURN_EDGES_MAX))
		else $error("loss held past the release edge count");
	a_hold_before_run: assert property (state_q == ST_PARK |=> state_q != ST_RUN)
		else $error("outputs resumed without the high/low step");
	a_hold_level: assert property (state_q == ST_HOLD && out_en_q |=> (OUT_TRUE == '1) && (OUT_COMP == '0))
		else $error("hold state does not drive high/low");
	a_oe_latency_edges: assert property ($changed(out_en_q) |-> $past(ref_rise) && $past(oe_cnt_q) == 3'(OE_LAT_EDGES - 1))
		else $error("enable applied at the wrong edge count");
	a_edge_keeps_present: assert property (ref_edge |=> !$rose(loss_q))
		else $error("loss raised right after an input edge");
	a_por_quiet: assert property (state_q == ST_POR |-> !loss_q && OUT_TRUE == '0 && !INPUT_CLOCK_LOSS_N_OE)
		else $error("activity before the first reference edge");
	a_por_release: assert property (state_q == ST_POR && ref_rise && pg_s |=> state_q == ST_RUN)
		else $error("first reference edge did not start the outputs");
	a_start_after_pd: assert property ($rose(pg_s) && state_q == ST_DOWN |-> ##[1:4] state_q == ST_RUN)
		else $error("start-up after power-down release too slow");
	a_park_pin_low: assert property (state_q == ST_PARK |-> INPUT_CLOCK_LOSS_N_OE && !INPUT_CLOCK_LOSS_N_O)
		else $error("loss pin released while parked");

	c_park_and_return: cover property (state_q == ST_PARK ##[1:300] state_q == ST_HOLD ##[1:300] state_q == ST_RUN);
	c_oe_switch_on: cover property ($rose(out_en_q));
	c_pd_release: cover property (state_q == ST_DOWN ##1 state_q == ST_RUN);
	c_loss_unparked: cover property ($rose(loss_q) && !park_en_q);
endmodule

// ---- shared/clmg_pkg.sv ----
package clmg_pkg;

	// Core clock
	localparam int CLK_PERIOD_NS   = 20;
	localparam int SYNC_STAGES     = 2;

	// Reference frequency window while parking is armed, in MHz
	localparam int REF_MIN_MHZ     = 25;
	localparam int REF_MAX_MHZ     = 400;
	localparam int REF_HALF_MAX_NS = 1000 / (2 * REF_MIN_MHZ);

	// Loss assert time: longest time, rounded down
	localparam int LOSS_ASSERT_NS  = 300;
	localparam int LOSS_ASSERT_CYC = (LOSS_ASSERT_NS / CLK_PERIOD_NS < 1) ? 1 : LOSS_ASSERT_NS / CLK_PERIOD_NS;
	// Silence window leaves room for the synchroniser, edge sample, silence flag, loss flag and
	// output register, so a pin edge just after a core edge still parks the outputs in time
	localparam int LOSS_SILENT_CYC = LOSS_ASSERT_CYC - SYNC_STAGES - 4;

	// Loss release, counted in reference rising edges
	localparam int RETURN_EDGES_MAX = 7;
	localparam int RETURN_EDGES     = 3;

	// Output enable latency, counted in reference rising edges
	localparam int OE_LAT_MIN   = 4;
	localparam int OE_LAT_MAX   = 6;
	localparam int OE_LAT_EDGES = 5;

	// Start-up after power-down release: longest time, rounded down
	localparam int STARTUP_NS  = 87;
	localparam int STARTUP_CYC = (STARTUP_NS / CLK_PERIOD_NS < 1) ? 1 : STARTUP_NS / CLK_PERIOD_NS;

	// Start-up after supply ramp: longest time, rounded down
	localparam int POWERUP_NS      = 1600000;
	localparam int POWERUP_CYC_DEF = POWERUP_NS / CLK_PERIOD_NS;

	// Register port
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h4;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h8;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hC;

	// Field positions and reset values
	localparam int CTRL_PARK_BIT = 4;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
	localparam int IRQ_W            = 3;
	localparam int IRQ_LOSS_SET_BIT = 0;
	localparam int IRQ_LOSS_CLR_BIT = 1;
	localparam int IRQ_LATE_BIT     = 2;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
	localparam int STAT_LOSS_BIT = 0;
	localparam int STAT_OE_BIT   = 1;
	localparam int STAT_ST_LSB   = 3;

	// Supervisor states, one-hot
	typedef enum logic [4:0] {
		ST_POR  = 5'h01,
		ST_DOWN = 5'h02,
		ST_RUN  = 5'h04,
		ST_PARK = 5'h08,
		ST_HOLD = 5'h10
	} clmg_state_t;

endpackage

// ---- logic/clmg_sync.sv ----
`timescale 1ns/1ns
module clmg_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Level in and out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1) begin : g_bad_width
		$error("clmg_sync: WIDTH must be at least 1");
	end

	// Two flops; the first is read only by the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ---- logic/clmg_edge_watch.sv ----
`timescale 1ns/1ns
module clmg_edge_watch #(
	parameter int SILENT_CYC = 11
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Synchronised reference level
	input  wire logic level,
	// Edge pulses and silence flag
	output logic      rise,
	output logic      any_edge,
	output logic      silent
);
	localparam int CW = $clog2(SILENT_CYC + 1);

	logic          prev_q;
	logic [CW-1:0] quiet_q;

	if (SILENT_CYC < 1) begin : g_bad_silent
		$error("clmg_edge_watch: SILENT_CYC must be at least 1");
	end

	// Edges seen against the last sampled level
	assign rise     = level & ~prev_q;
	assign any_edge = level ^ prev_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= level;
		end
	end

	// Only edges count as presence; no frequency is judged here
	always_ff @(posedge clk) begin
		if (rst) begin
			quiet_q <= '0;
			silent  <= 1'b0;
		end else if (any_edge) begin
			quiet_q <= '0;
			silent  <= 1'b0;
		end else if (quiet_q != CW'(SILENT_CYC)) begin
			quiet_q <= quiet_q + 1'b1;
		end else begin
			silent  <= 1'b1;
		end
	end
endmodule

// ---- bench/clmg_ref_src.sv ----
`timescale 1ns/1ns
module clmg_ref_src (
	// Control from the bench
	input  wire logic       run,
	input  wire logic [7:0] half_ns,
	// Loss pin as driven by the block
	input  wire logic       sink_data,
	input  wire logic       sink_en,
	// Reference clock and resolved loss pin
	output logic            ref_clk,
	output wire logic       loss_pin_n
);
	// External pull-up holds the pin high unless the block sinks it
	assign loss_pin_n = sink_en ? sink_data : 1'h1;

	// Reference stands still at its last level while stopped, as a dead source would
	initial begin
		ref_clk = 1'h0;
		forever begin
			#(half_ns);
			if (run)
				ref_clk = ~ref_clk;
		end
	end
endmodule

// ---- bench/clock_loss_monitor_gate_tb.sv ----
`timescale 1ns/1ns
module clock_loss_monitor_gate_tb;
	import clmg_pkg::*;
	localparam int NOUT = 4;
	localparam logic [NOUT-1:0] ALL1 = 4'hF;
	logic              clk;
	logic              rst;
	logic              oe_n;
	logic              pg_n;
	logic              run;
	logic [7:0]        half_ns;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rdata;
	logic [NOUT-1:0]   o_t;
	logic [NOUT-1:0]   o_c;
	logic              ref_clk;
	logic              sink_d;
	logic              sink_en;
	logic              irq;
	wire logic         loss_n;
	int                bad_count;
	int                n_checks;
	int                edges;
	int                n;
	int                m;
	time               last_t;
	logic [DATA_W-1:0] d;

	// Core clock
	initial begin
		clk = 1'h0;
		forever #(CLK_PERIOD_NS / 2) clk = ~clk;
	end

	// Reference rising edges and time of the last toggle, for latency figures
	always @(ref_clk) begin
		last_t = $time;
		if (ref_clk)
			edges++;
	end

	clmg_ref_src src (.run(run), .half_ns(half_ns), .sink_data(sink_d), .sink_en(sink_en),
		.ref_clk(ref_clk), .loss_pin_n(loss_n));

	clmg_top #(.NUM_OUTPUTS(NOUT), .POWERUP_CYC(50)) dut (.CORE_CLK(clk), .RESET(rst),
		.REFERENCE_CLOCK_IN(ref_clk), .OUTPUT_ENABLE_N(oe_n), .POWER_GOOD_POWERDOWN_N(pg_n),
		.OUT_TRUE(o_t), .OUT_COMP(o_c), .INPUT_CLOCK_LOSS_N_O(sink_d), .INPUT_CLOCK_LOSS_N_OE(sink_en),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq));

	// Value and range comparisons
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask

	task automatic check_in(string what, int lo, int hi, int got);
		n_checks++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
		end
	endtask

	// Register port cycles; read data is taken in the one cycle it stands
	task automatic reg_wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'h0;
		#1;
	endtask

	task automatic reg_rd(logic [ADDR_W-1:0] a);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask

	task automatic cyc();
		@(posedge clk);
		#1;
	endtask

	function automatic logic parked();
		return (o_t === '0) && (o_c === '0);
	endfunction

	task automatic done(string name);
		$display("test %s finished", name);
	endtask

	// No reference yet: no loss, overdue flag, register reset values
	task automatic t_powerup();
		repeat (60) cyc();
		check("loss pin before first edge", 1'h1, loss_n);
		reg_rd(REG_IRQ_STAT);
		check("overdue flag", 8'h04, d);
		reg_rd(REG_STATUS);
		check("state bits", 8'h08, d & 8'hF9);
		reg_rd(REG_CTRL);
		check("ctrl reset", CTRL_RESET, d);
		reg_rd(REG_IRQ_MASK);
		check("mask reset", 8'h00, d);
		reg_rd(4'h2);
		check("unmapped read", 8'h00, d);
		reg_wr(REG_IRQ_STAT, 8'h04);
		reg_rd(REG_IRQ_STAT);
		check("overdue cleared", 8'h00, d);
		run <= 1'h1;
		for (n = 0; n < 50 && parked(); n++) cyc();
		check_in("cycles to first output", 0, 49, n);
		done("powerup");
	endtask

	// Loss without parking, interrupt masking and clearing, return at another rate
	task automatic t_loss();
		@(posedge clk) run <= 1'h0;
		for (n = 0; n < 40 && loss_n !== 1'h0; n++) cyc();
		check_in("loss assert ns", 0, LOSS_ASSERT_NS, int'($time - last_t) - 1);
		check("outputs hold static level", ALL1, o_t ^ o_c);
		reg_rd(REG_IRQ_STAT);
		check("loss event", 8'h01, d & 8'h01);
		check("irq masked", 1'h0, irq);
		reg_wr(REG_IRQ_MASK, 8'h03);
		check("irq unmasked", 1'h1, irq);
		reg_wr(REG_IRQ_STAT, 8'h01);
		check("irq cleared", 1'h0, irq);
		half_ns = 8'h64;
		n = edges;
		run <= 1'h1;
		for (m = 0; m < 300 && loss_n !== 1'h1; m++) cyc();
		check_in("edges to release", 1, RETURN_EDGES_MAX, edges - n);
		check("irq on release", 1'h1, irq);
		reg_wr(REG_IRQ_STAT, 8'h02);
		check("irq cleared again", 1'h0, irq);
		done("loss");
	endtask

	// Parking: low/low on loss, high/low first on return, then toggling
	task automatic t_park();
		reg_wr(REG_CTRL, 8'h10);
		reg_rd(REG_CTRL);
		check("ctrl park bit", 8'h10, d);
		@(posedge clk) run <= 1'h0;
		for (n = 0; n < 40 && !parked(); n++) cyc();
		check_in("park ns", 0, LOSS_ASSERT_NS, int'($time - last_t) - 1);
		n = edges;
		run <= 1'h1;
		for (m = 0; m < 300 && parked(); m++) cyc();
		check("first true after park", ALL1, o_t);
		check("first comp after park", 4'h0, o_c);
		for (m = 0; m < 300 && loss_n !== 1'h1; m++) cyc();
		check_in("edges to release parked", 1, RETURN_EDGES_MAX, edges - n);
		for (m = 0; m < 40 && o_c !== ALL1; m++) cyc();
		check("toggling resumed", ALL1, o_c);
		reg_wr(REG_CTRL, 8'h00);
		done("park");
	endtask

	// Output enable latency in reference edges, both directions
	task automatic t_oe();
		n = edges;
		@(posedge clk) oe_n <= 1'h1;
		for (m = 0; m < 200 && !parked(); m++) cyc();
		check_in("edges to stop", OE_LAT_MIN, OE_LAT_MAX, edges - n);
		n = edges;
		@(posedge clk) oe_n <= 1'h0;
		for (m = 0; m < 200 && parked(); m++) cyc();
		check_in("edges to start", OE_LAT_MIN, OE_LAT_MAX, edges - n);
		done("oe");
	endtask

	// Power down in mid loss, then release with the reference running
	task automatic t_pwrdn();
		@(posedge clk) run <= 1'h0;
		for (m = 0; m < 40 && loss_n !== 1'h0; m++) cyc();
		@(posedge clk) pg_n <= 1'h0;
		repeat (6) cyc();
		check("loss released when down", 1'h1, loss_n);
		check("outputs off when down", 1'h1, parked());
		run <= 1'h1;
		repeat (40) cyc();
		@(posedge clk) pg_n <= 1'h1;
		for (m = 0; m < 20 && parked(); m++) cyc();
		check_in("cycles to first edge", 1, STARTUP_CYC, m);
		done("powerdown");
	endtask

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst = 1'h1;
		oe_n = 1'h0;
		pg_n = 1'h1;
		run = 1'h0;
		half_ns = 8'h3C;
		addr = '0;
		wdata = '0;
		wr = 1'h0;
		rd = 1'h0;
		bad_count = 0;
		n_checks = 0;
		edges = 0;
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		t_powerup();
		t_loss();
		t_park();
		t_oe();
		t_pwrdn();
		complete_run();
	end

	// Watchdog: the tests need a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run();
	end
endmodule
